// >>> cis_core.sv
/*
 Interrupt sequencer of an 8-bit core: flags, enables, priority pick,
 entry and return sequences, stack pushes and pops, AXI4-Lite registers.
 Assumes the core reports each retired instruction with a one-cycle pulse,
 stalls while core_hold is high, and that fuse and lock inputs are stable
 on-chip levels in this clock domain.
*/
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// How it works
// [R1] Reset and each source own a vector
// [R2] Take needs source enable and global enable
// [R3] Lock bits suppress interrupts by PC region
// [R4] Lower vector address wins; reset first
// [R5] Base select moves vectors to boot
// [R6] Boot fuse moves reset vector to boot
// [R7] Taking an interrupt clears global enable
// [R8] Software setting global enable allows nesting
// [R9] Return sets global enable
// [R10] Hardware clears flag when vectoring
// [R11] Writing one clears a flag
// [R12] Flag held while source disabled
// [R13] Flags held while globally disabled, serviced by priority
// [R14] Level sources request only while present
// [R15] One main instruction after return first
// [R16] Software saves status register itself
// [R17] Global disable acts at once
// [R18] Instruction after global enable runs first
// [R19] Entry takes four cycles, pushes PC
// [R20] Multi-cycle instruction completes before entry
// [R21] Wake adds four cycles to entry
// [R22] Return takes four cycles, pops PC
// [R23] Entry push decrements stack pointer by two
// [R24] Vector is base plus per-source offset
module cis_core import cis_pkg::*; #(
   parameter int N_SRC = 8,
   parameter logic [N_SRC-1:0] LEVEL_MASK = '0,
   parameter logic [15:0] BOOT_START = 16'hf000
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // AXI4-Lite slave.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt sources.
   input wire logic [N_SRC-1:0] src_event,
   input wire logic [N_SRC-1:0] src_level,
   // Fuse and lock levels.
   input wire logic reset_vector_boot_fuse,
   input wire logic app_section_lock_bit,
   input wire logic boot_section_lock_bit,
   // Core side.
   input wire cis_op_s core_op,
   input wire logic core_sleeping,
   input wire logic [15:0] core_pc,
   input wire logic [7:0] stk_rdata,
   output logic core_hold,
   output cis_pc_s vec_load,
   output cis_pc_s ret_load,
   output cis_stk_s stk,
   output logic [15:0] reset_vector,
   output logic global_en
);

   localparam int IDX_W = (N_SRC > 1) ? $clog2(N_SRC) : 1;

   cis_state_e state_r;
   logic [2:0] cnt_r;
   logic [N_SRC-1:0] flag_r;
   logic [N_SRC-1:0] en_r;
   logic vector_base_select;
   logic [15:0] sp_r;
   logic [15:0] pc_save_r;
   logic [IDX_W-1:0] win_r;
   logic [31:0] wmask;
   logic wr_go;
   logic rd_go;
   logic [N_SRC-1:0] ev_w;
   logic [N_SRC-1:0] req_w;
   logic [N_SRC-1:0] wclr_w;
   logic [IDX_W-1:0] win_idx;
   logic [15:0] vec_base;
   logic pc_in_app;
   logic suppress;
   logic boundary;
   logic take_w;
   logic return_from_irq_instr_go;

   function automatic logic [IDX_W-1:0] pick(input logic [N_SRC-1:0] r);
      logic [IDX_W-1:0] p;
      p = '0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (r[i]) begin
            p = IDX_W'(i);
         end
      end
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   // Bus handshakes complete in the cycle of the ready pulse.
   assign wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
   assign rd_go = s_axi_arready && s_axi_arvalid;
   assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   assign wclr_w = (wr_go && s_axi_awaddr == CIS_OFF_FLAGS) ? N_SRC'(s_axi_wdata & wmask) : '0; // R11

   // Request, priority and suppression terms.
   assign ev_w = src_event & ~LEVEL_MASK;
   assign req_w = ((flag_r & ~LEVEL_MASK) | (src_level & LEVEL_MASK)) & en_r; // R2 R12 R14
   assign win_idx = pick(req_w); // R4
   assign vec_base = vector_base_select ? BOOT_START : 16'h0000; // R5
   assign pc_in_app = core_pc < BOOT_START;
   // A locked section may not be left for the other one through a vector.
   assign suppress = (boot_section_lock_bit && !vector_base_select && !pc_in_app) ||
                     (app_section_lock_bit && vector_base_select && pc_in_app); // R3
   // Entry starts only at an instruction boundary or out of sleep.
   assign boundary = (core_op.retire && !core_op.cli && !core_op.sei && !core_op.return_from_irq_instr) || core_sleeping; // R17 R18 R20
   assign take_w = state_r == CIS_ST_RUN && boundary && global_en && |req_w && !suppress; // R2 R13 R15
   assign return_from_irq_instr_go = state_r == CIS_ST_RUN && core_op.retire && core_op.return_from_irq_instr;

   ////////////////////////////////////////////////////////////////////////////

   // Write address and data are taken together by a one-cycle ready pulse.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CIS_RESP_OK;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr == CIS_OFF_CTRL || s_axi_awaddr == CIS_OFF_ENABLE ||
                            s_axi_awaddr == CIS_OFF_FLAGS || s_axi_awaddr == CIS_OFF_STATUS ||
                            s_axi_awaddr == CIS_OFF_SP) ? CIS_RESP_OK : CIS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel; unmapped offsets read zero with an error response.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= CIS_RESP_OK;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= CIS_RESP_OK;
            unique case (s_axi_araddr)
               CIS_OFF_CTRL: s_axi_rdata <= {29'h0, reset_vector_boot_fuse, vector_base_select, global_en};
               CIS_OFF_ENABLE: s_axi_rdata <= 32'(en_r);
               CIS_OFF_FLAGS: s_axi_rdata <= 32'(flag_r);
               CIS_OFF_STATUS: s_axi_rdata <= {20'h0, 4'(win_idx), 4'(state_r)};
               CIS_OFF_SP: s_axi_rdata <= {16'h0, sp_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= CIS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // Enables and vector base select, written by software only.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         en_r <= '0;
         vector_base_select <= 1'b0;
      end else if (wr_go) begin
         if (s_axi_awaddr == CIS_OFF_ENABLE) begin
            en_r <= (en_r & ~N_SRC'(wmask)) | N_SRC'(s_axi_wdata & wmask);
         end
         if (s_axi_awaddr == CIS_OFF_CTRL && s_axi_wstrb[0]) begin
            vector_base_select <= s_axi_wdata[CIS_CTRL_VBS]; // R5
         end
      end
   end

   // Flags: an event in the clearing cycle wins over both clears.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flag_r <= '0;
      end else begin
         flag_r <= (flag_r & ~wclr_w & ~(take_w ? N_SRC'(1) << win_idx : '0)) | ev_w; // R10 R11 R12 R13
      end
   end

   // Global enable bit of the status register.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         global_en <= CIS_GIE_RST;
      end else if (take_w) begin
         global_en <= 1'b0; // R7
      end else if (state_r == CIS_ST_RETURN && cnt_r == 3'(CIS_RETURN_FROM_IRQ_INSTR_CYC - 1)) begin
         global_en <= 1'b1; // R9
      end else if (core_op.retire && core_op.cli) begin
         global_en <= 1'b0; // R17
      end else if (core_op.retire && core_op.sei) begin
         global_en <= 1'b1; // R8 R18
      end else if (wr_go && s_axi_awaddr == CIS_OFF_CTRL && s_axi_wstrb[0]) begin
         global_en <= s_axi_wdata[CIS_CTRL_GIE]; // R8
      end
   end

   // Reset vector follows the boot fuse.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reset_vector <= 16'h0000;
      end else begin
         reset_vector <= reset_vector_boot_fuse ? BOOT_START : 16'h0000; // R1 R6
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // Entry and return sequencer; also owns the stack pointer.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r <= CIS_ST_RUN;
         cnt_r <= 3'h0;
         core_hold <= 1'b0;
         win_r <= '0;
         pc_save_r <= 16'h0000;
         sp_r <= CIS_SP_RST;
         vec_load <= '0;
         ret_load <= '0;
         stk <= '0;
      end else begin
         vec_load.valid <= 1'b0;
         ret_load.valid <= 1'b0;
         stk.we <= 1'b0;
         stk.re <= 1'b0;
         if (wr_go && s_axi_awaddr == CIS_OFF_SP) begin
            sp_r <= (sp_r & ~wmask[15:0]) | (s_axi_wdata[15:0] & wmask[15:0]);
         end
         unique case (state_r)
            CIS_ST_RUN: begin
               cnt_r <= 3'h0;
               if (take_w) begin
                  win_r <= win_idx;
                  pc_save_r <= core_pc;
                  core_hold <= 1'b1;
                  state_r <= core_sleeping ? CIS_ST_WAKE : CIS_ST_ENTRY; // R21
               end else if (return_from_irq_instr_go) begin
                  core_hold <= 1'b1;
                  state_r <= CIS_ST_RETURN;
               end
            end
            CIS_ST_WAKE: begin
               cnt_r <= cnt_r + 3'h1;
               if (cnt_r == 3'(CIS_WAKE_CYC - 1)) begin
                  cnt_r <= 3'h0;
                  state_r <= CIS_ST_ENTRY; // R21
               end
            end
            CIS_ST_ENTRY: begin
               cnt_r <= cnt_r + 3'h1;
               if (cnt_r == 3'h0) begin
                  stk.we <= 1'b1; // R19
                  stk.addr <= sp_r;
                  stk.wdata <= pc_save_r[7:0];
               end else if (cnt_r == 3'h1) begin
                  stk.we <= 1'b1;
                  stk.addr <= sp_r - 16'h0001;
                  stk.wdata <= pc_save_r[15:8];
                  sp_r <= sp_r - 16'h0002; // R23
               end else if (cnt_r == 3'(CIS_ENTRY_CYC - 1)) begin
                  core_hold <= 1'b0;
                  vec_load.valid <= 1'b1;
                  vec_load.pc <= vec_base + 16'((32'(win_r) + 1) * CIS_VEC_STRIDE); // R1 R24
                  state_r <= CIS_ST_RUN;
               end
            end
            CIS_ST_RETURN: begin
               cnt_r <= cnt_r + 3'h1;
               if (cnt_r == 3'h0) begin
                  stk.re <= 1'b1; // R22
                  stk.addr <= sp_r + 16'h0001;
               end else if (cnt_r == 3'h1) begin
                  ret_load.pc[15:8] <= stk_rdata;
                  stk.re <= 1'b1;
                  stk.addr <= sp_r + 16'h0002;
               end else if (cnt_r == 3'h2) begin
                  ret_load.pc[7:0] <= stk_rdata;
                  sp_r <= sp_r + 16'h0002; // R22
               end else begin
                  core_hold <= 1'b0;
                  ret_load.valid <= 1'b1; // R15
                  state_r <= CIS_ST_RUN;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // Checks on the sequencer.
   sequence s_hold4;
      core_hold [*4];
   endsequence

   property p_cli_now;
      @(posedge sys_clk) disable iff (!rst_n)
      core_op.retire && core_op.cli |=> !core_hold && !global_en;
   endproperty
   a_cli_now: assert property (p_cli_now) else $error("interrupt taken on global disable"); // R17

   property p_sei_defer;
      @(posedge sys_clk) disable iff (!rst_n)
      state_r == CIS_ST_RUN && core_op.retire && core_op.sei && !global_en |=> !core_hold;
   endproperty
   a_sei_defer: assert property (p_sei_defer) else $error("entry before the instruction after enable"); // R18

   property p_entry;
      @(posedge sys_clk) disable iff (!rst_n)
      take_w && !core_sleeping |=> s_hold4 ##1 (!core_hold && vec_load.valid);
   endproperty
   a_entry: assert property (p_entry) else $error("entry length is not four cycles"); // R19

   property p_wake;
      @(posedge sys_clk) disable iff (!rst_n)
      take_w && core_sleeping |=> core_hold [*8] ##1 vec_load.valid;
   endproperty
   a_wake: assert property (p_wake) else $error("wake entry is not eight cycles"); // R21

   property p_return_from_irq_instr;
      @(posedge sys_clk) disable iff (!rst_n)
      return_from_irq_instr_go |=> s_hold4 ##1 (global_en && ret_load.valid && !core_hold);
   endproperty
   a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return sequence wrong"); // R9 R22

   property p_sp_push;
      @(posedge sys_clk) disable iff (!rst_n)
      take_w && !core_sleeping && !(wr_go && s_axi_awaddr == CIS_OFF_SP) ##1
         !(wr_go && s_axi_awaddr == CIS_OFF_SP) [*3] |-> sp_r == $past(sp_r, 3) - 16'h0002;
   endproperty
   a_sp_push: assert property (p_sp_push) else $error("stack pointer not lowered by two"); // R23

   property p_gie_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      take_w |=> !global_en [*4];
   endproperty
   a_gie_clear: assert property (p_gie_clear) else $error("global enable not cleared on entry"); // R7

   property p_flag_clr;
      @(posedge sys_clk) disable iff (!rst_n)
      take_w && !LEVEL_MASK[win_idx] && !ev_w[win_idx] |=> !flag_r[win_r];
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared on vectoring"); // R10

   property p_no_take_disabled;
      @(posedge sys_clk) disable iff (!rst_n)
      take_w |-> en_r[win_idx] && global_en && !suppress;
   endproperty
   a_no_take_disabled: assert property (p_no_take_disabled) else $error("disabled source taken"); // R2 R3

endmodule

// >>> cis_core_model.sv
/*
 Far-side model: the core program counter and its byte-wide stack memory.
 Assumes the bench drives core_op and that a stack read answers within the
 cycle in which its strobe stands, as the sequencer samples it at that edge.
*/
`timescale 1ns/1ps
module cis_core_model import cis_pkg::*; (
   // Clock.
   input wire logic sys_clk,
   // Sequencer side.
   input wire cis_op_s core_op,
   input wire cis_pc_s vec_load,
   input wire cis_pc_s ret_load,
   input wire cis_stk_s stk,
   output logic [15:0] core_pc,
   output logic [7:0] stk_rdata
);
   logic [7:0] mem [0:65535];
   ////////////////////////////////////////////////////////////////////////////
   // Program counter starts in the application area.
   initial begin
      core_pc = 16'h0100;
   end
   // Jumps win; a retire reports a whole instruction, never a part.
   always @(posedge sys_clk) begin
      if (vec_load.valid) begin
         core_pc <= vec_load.pc;
      end else if (ret_load.valid) begin
         core_pc <= ret_load.pc;
      end else if (core_op.retire) begin
         core_pc <= core_pc + 16'h0001;
      end
   end
   // Stack stores bytes on the clock edge after a write strobe.
   always @(posedge sys_clk) begin
      if (stk.we) begin
         mem[stk.addr] <= stk.wdata;
      end
   end
   // A read answers in the cycle of its strobe; idle data is a filler byte.
   assign stk_rdata = stk.re ? mem[stk.addr] : 8'h5a;
endmodule

// >>> cis_core_tb_top.sv
/*
 Self-checking bench of the interrupt sequencer with a core model.
 Assumes the default source count, no level sources and a 25 ns clock.
*/
`timescale 1ns/1ps
module cis_core_tb_top import cis_pkg::*; ;
   localparam logic [15:0] BOOT = 16'hf000;
   localparam cis_op_s OP_RET = 4'h8;
   localparam cis_op_s OP_RETURN_FROM_IRQ_INSTR = 4'hc;
   localparam cis_op_s OP_SEI = 4'ha;
   localparam cis_op_s OP_CLI = 4'h9;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, hold, gen;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   logic [7:0] ev = 8'h00;
   logic [7:0] stk_rdata;
   logic alock = 1'b0, sleeping = 1'b0;
   cis_op_s op = '0;
   logic [15:0] core_pc, rst_vec, mypc;
   cis_pc_s vec_load, ret_load;
   cis_stk_s stk;
   int fails = 0, cmp_count = 0, n, a, b;
   logic [15:0] q[$];
   ////////////////////////////////////////////////////////////////////////////
   // Design and core model.
   cis_core u_cis_core (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .src_event(ev), .src_level(8'h00),
      .reset_vector_boot_fuse(1'b1), .app_section_lock_bit(alock),
      .boot_section_lock_bit(1'b0), .core_op(op), .core_sleeping(sleeping),
      .core_pc(core_pc), .stk_rdata(stk_rdata), .core_hold(hold),
      .vec_load(vec_load), .ret_load(ret_load), .stk(stk),
      .reset_vector(rst_vec), .global_en(gen));
   cis_core_model u_cis_core_model (.sys_clk(sys_clk), .core_op(op),
      .vec_load(vec_load), .ret_load(ret_load), .stk(stk), .core_pc(core_pc),
      .stk_rdata(stk_rdata));
   ////////////////////////////////////////////////////////////////////////////
   // Clock.
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Compares one value and counts it.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic report_and_stop;
      $display("compares=%0d mismatches=%0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // One register write; address and data are offered together.
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge sys_clk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1) @(posedge sys_clk);
      bready <= 1'b0;
      chk(bresp, CIS_RESP_OK);
   endtask
   // One register read into rd and rs.
   task automatic axi_rd(input logic [7:0] ad);
      @(posedge sys_clk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge sys_clk);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // One source pulse per set bit.
   task automatic raise(input logic [7:0] m);
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 8'h00;
   endtask
   // Retires one instruction (or sleeps) and times the following jump.
   task automatic step(input cis_op_s o, input logic slp, input int en, input logic [15:0] epc);
      cis_pc_s got;
      @(posedge sys_clk);
      op <= o;
      sleeping <= slp;
      #1 mypc = core_pc;
      @(posedge sys_clk);
      op <= '0;
      sleeping <= 1'b0;
      n = 0;
      got = '0;
      while (n < 12 && got.valid !== 1'b1) begin
         @(posedge sys_clk);
         #1 n++;
         got = (vec_load.valid === 1'b1) ? vec_load : ret_load;
      end
      chk(got.valid ? n : 0, en);
      if (en != 0) begin
         chk(got.pc, epc);
      end
      if (en != 0 && !o.return_from_irq_instr) begin
         q.push_back(mypc);
      end
   endtask
   // Expected vector of a source from the chosen base.
   function automatic logic [15:0] vec(input int idx, input logic vbs);
      return (vbs ? BOOT : 16'h0000) + 16'((idx + 1) * CIS_VEC_STRIDE);
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog: the whole run needs well under 4000 cycles.
   initial begin
      #(25 * 4000);
      fails++;
      report_and_stop();
   end
   // Main sequence.
   initial begin
      void'($urandom(7));
      a = $urandom_range(0, 3);
      b = a + $urandom_range(1, 3);
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      #1 chk(gen, 0);
      chk(rst_vec, BOOT);
      axi_wr(CIS_OFF_SP, 32'h0000_0200);
      axi_rd(CIS_OFF_CTRL);
      chk(rd, 32'h4);
      axi_rd(8'h40);
      chk(rs, CIS_RESP_SLVERR);
      $display("test reset and registers done");
      // Flags stay while disabled; writing one clears, zero keeps.
      raise(8'h80 | (8'h01 << a) | (8'h01 << b));
      axi_rd(CIS_OFF_FLAGS);
      chk(rd, 32'h80 | (1 << a) | (1 << b));
      step(OP_RET, 1'b0, 0, 16'h0);
      axi_wr(CIS_OFF_FLAGS, 32'h80);
      axi_rd(CIS_OFF_FLAGS);
      chk(rd, (1 << a) | (1 << b));
      axi_wr(CIS_OFF_ENABLE, (1 << a) | (1 << b));
      $display("test flags done");
      // Disable acts at once; enable waits one instruction.
      axi_wr(CIS_OFF_CTRL, 32'h1);
      step(OP_CLI, 1'b0, 0, 16'h0);
      chk(gen, 0);
      step(OP_SEI, 1'b0, 0, 16'h0);
      chk(gen, 1);
      step(OP_RET, 1'b0, CIS_ENTRY_CYC, vec(a, 0));
      chk(gen, 0);
      axi_rd(CIS_OFF_FLAGS);
      chk(rd, 1 << b);
      axi_rd(CIS_OFF_SP);
      chk(rd, 32'h1fe);
      $display("test entry done");
      // Nesting, then both returns in order.
      axi_wr(CIS_OFF_CTRL, 32'h1);
      step(OP_RET, 1'b0, CIS_ENTRY_CYC, vec(b, 0));
      axi_rd(CIS_OFF_SP);
      chk(rd, 32'h1fc);
      step(OP_RETURN_FROM_IRQ_INSTR, 1'b0, CIS_RETURN_FROM_IRQ_INSTR_CYC, q.pop_back());
      step(OP_RETURN_FROM_IRQ_INSTR, 1'b0, CIS_RETURN_FROM_IRQ_INSTR_CYC, q.pop_back());
      chk(gen, 1);
      axi_rd(CIS_OFF_SP);
      chk(rd, 32'h200);
      $display("test nesting done");
      // Boot base, wake from sleep, lock suppression.
      axi_wr(CIS_OFF_CTRL, 32'h3);
      raise(8'h01 << a);
      step('0, 1'b1, CIS_ENTRY_CYC + CIS_WAKE_CYC, vec(a, 1));
      step(OP_RETURN_FROM_IRQ_INSTR, 1'b0, CIS_RETURN_FROM_IRQ_INSTR_CYC, q.pop_back());
      @(posedge sys_clk);
      alock <= 1'b1;
      raise(8'h01 << a);
      step(OP_RET, 1'b0, 0, 16'h0);
      @(posedge sys_clk);
      alock <= 1'b0;
      step(OP_RET, 1'b0, CIS_ENTRY_CYC, vec(a, 1));
      step(OP_RETURN_FROM_IRQ_INSTR, 1'b0, CIS_RETURN_FROM_IRQ_INSTR_CYC, q.pop_back());
      $display("test boot base done");
      report_and_stop();
   end
endmodule

// >>> cis_pkg.sv
/*
 Shared constants and carrier types of the interrupt sequencer.
 Assumes one core clock and an AXI4-Lite slave with 32-bit data.
*/
package cis_pkg;

   // Register byte offsets.
   localparam logic [7:0] CIS_OFF_CTRL = 8'h00;
   localparam logic [7:0] CIS_OFF_ENABLE = 8'h04;
   localparam logic [7:0] CIS_OFF_FLAGS = 8'h08;
   localparam logic [7:0] CIS_OFF_STATUS = 8'h0c;
   localparam logic [7:0] CIS_OFF_SP = 8'h10;

   // Field positions in the control register.
   localparam int CIS_CTRL_GIE = 0;
   localparam int CIS_CTRL_VBS = 1;
   localparam int CIS_CTRL_FUSE = 2;

   // Reset values.
   localparam logic [15:0] CIS_SP_RST = 16'h0000;
   localparam logic CIS_GIE_RST = 1'b0;

   // Cycle counts of entry, wake-up extension and return.
   localparam int CIS_ENTRY_CYC = 4;
   localparam int CIS_WAKE_CYC = 4;
   localparam int CIS_RETURN_FROM_IRQ_INSTR_CYC = 4;
   // Words between vectors (one two-word jump each).
   localparam int CIS_VEC_STRIDE = 2;

   localparam logic [1:0] CIS_RESP_OK = 2'b00;
   localparam logic [1:0] CIS_RESP_SLVERR = 2'b10;

   // Sequencer states.
   typedef enum logic [3:0] {
      CIS_ST_RUN = 4'b0001,
      CIS_ST_WAKE = 4'b0010,
      CIS_ST_ENTRY = 4'b0100,
      CIS_ST_RETURN = 4'b1000
   } cis_state_e;

   // Instruction retire report from the core.
   typedef struct packed {
      logic retire;
      logic return_from_irq_instr;
      logic sei;
      logic cli;
   } cis_op_s;

   // Byte-wide stack port toward data memory.
   typedef struct packed {
      logic we;
      logic re;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cis_stk_s;

   // Program counter load toward the core.
   typedef struct packed {
      logic valid;
      logic [15:0] pc;
   } cis_pc_s;

endpackage
